/* design/tbx_pkg.sv */
// Package of constants and carrier types for the two-wire bus extender
package tbx_pkg;

  // Core clock period and the documented intervals, in nanoseconds
  localparam int unsigned SYS_CLK_PERIOD_NS = 20;
  localparam int unsigned DRV_ON_NS         = 1750;
  localparam int unsigned HOLDOFF_NS        = 2500;

  // Least times round up to whole core clock cycles
  localparam int unsigned DRV_ON_CYC  =
    (DRV_ON_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned HOLDOFF_CYC =
    (HOLDOFF_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Interval counter sizing and its value after reset
  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX   = 8'hff;
  localparam logic [CNT_W-1:0] DRV_ON_LAST  = CNT_W'(DRV_ON_CYC - 1);
  localparam logic [CNT_W-1:0] HOLDOFF_LAST = CNT_W'(HOLDOFF_CYC - 1);

  // Comparator results for one side of a channel
  typedef struct packed {
    logic below_high_fall;     // Below high_fall_threshold (75 %)
    logic above_low_release;   // Above low_release_threshold
    logic above_85;            // Above 85 % of the side supply
    logic below_60;            // Below 60 % of the side supply
  } tbx_side_lvl_t;

  typedef struct packed {
    tbx_side_lvl_t cable;
    tbx_side_lvl_t disp;
  } tbx_chan_lvl_t;

  // Output enables of one side; high while the device drives the pin
  typedef struct packed {
    logic pull_low_oe;         // Strong low driver
    logic pull_high_oe;        // Strong pull-up, cable side only
    logic hold_oe;             // Weak clamp at the hold-low level
  } tbx_side_drv_t;

  typedef struct packed {
    tbx_side_drv_t cable;
    tbx_side_drv_t disp;
  } tbx_chan_drv_t;

  localparam tbx_chan_drv_t DRV_OFF = '0;
  localparam tbx_chan_lvl_t LVL_RESET = '0;

  // Channel controller states, one-hot
  typedef enum logic [3:0] {
    ST_HIGH      = 4'h1,       // Idle high, sensing on
    ST_LOW_HOLD  = 4'h2,       // Low holdoff, sensing off
    ST_LOW       = 4'h4,       // Low, sensing on
    ST_HIGH_HOLD = 4'h8        // High holdoff, sensing off; data still senses a drop below 60 %
  } tbx_state_t;

endpackage

/* design/tbx_top.sv */
// Two-wire bus extender: clock and data channel controllers with link side
//
// Overview of operation
// - Idle high: every driver of the channel is off and sensing is on.
// - A fall below 75 % on a side drives both low and starts the holdoff.
// - Strong drivers stay on 1.75 us after each decision, or until data leaves the high holdoff early, then go off.
// - Every holdoff lasts 2.5 us with input changes ignored, except that data can leave the high holdoff early.
// - In series mode the low holdoff clamps each side at the hold level.
// - At the end of the low holdoff drivers go off and sensing resumes.
// - In series mode a lone released side is clamped until the other goes.
// - Both sides released: 1.75 us cable pull-up and a high holdoff start.
// - After the high holdoff the channel idles once both sides exceed 85 %.
// - Data alone also leaves the high holdoff when a side drops below 60 %.
// - Clock and data have separate, independent wired-AND controllers.
// - A low driver_enable_input turns every driver off, isolating the buses.
// - Mode high selects parallel operation, mode low isolating series.

module tbx_chan
  import tbx_pkg::*;
#(
  parameter bit IS_DATA = 1'b0
) (
  input  wire logic          sys_clk,
  input  wire logic          reset_n,
  input  wire tbx_chan_lvl_t lvl,
  input  wire logic          drv_en,
  input  wire logic          series,
  output tbx_chan_drv_t      drv
);

  tbx_state_t         state;
  tbx_state_t         next_state;
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  tbx_chan_drv_t      next_drv;
  logic               any_fall;
  logic               both_rel;
  logic               both_hi;
  logic               any_lo60;
  logic               hold_done;
  logic               armed;
  logic               next_armed;

  assign any_fall  = lvl.cable.below_high_fall | lvl.disp.below_high_fall;
  assign both_rel  = lvl.cable.above_low_release & lvl.disp.above_low_release;
  assign both_hi   = lvl.cable.above_85 & lvl.disp.above_85;
  assign any_lo60  = lvl.cable.below_60 | lvl.disp.below_60;
  assign hold_done = (cnt >= HOLDOFF_LAST);

  // Next state and interval count; the counter saturates so it never wraps
  always_comb begin
    next_state = state;
    next_cnt   = (cnt == CNT_MAX) ? cnt : cnt + 8'h01;
    // A drop counts only after both sides were seen above 60 % in this
    // holdoff: sensed levels lag the pins, so the clamp left from the low
    // state would otherwise read as a fresh drop
    next_armed = (state == ST_HIGH_HOLD) && (armed || !any_lo60);
    unique case (state)
      ST_HIGH: begin
        if (any_fall) begin
          next_state = ST_LOW_HOLD;
          next_cnt   = CNT_RESET;
        end
      end
      ST_LOW_HOLD: begin
        // Inputs are not looked at until the holdoff is over
        if (hold_done) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (both_rel) begin
          next_state = ST_HIGH_HOLD;
          next_cnt   = CNT_RESET;
        end
      end
      ST_HIGH_HOLD: begin
        if (IS_DATA && armed && any_lo60) begin
          next_state = ST_HIGH;
        end else if (hold_done && both_hi) begin
          next_state = ST_HIGH;
        end
      end
      default: begin
        next_state = ST_HIGH;
      end
    endcase
    // Disabled drivers park the controller idle so it restarts cleanly
    if (!drv_en) begin
      next_state = ST_HIGH;
      next_cnt   = CNT_RESET;
    end
  end

  // Drive pattern follows the next state, so drive and state stay aligned
  always_comb begin
    next_drv = DRV_OFF;
    unique case (next_state)
      ST_LOW_HOLD: begin
        if (next_cnt <= DRV_ON_LAST) begin
          next_drv.cable.pull_low_oe = 1'b1;
          next_drv.disp.pull_low_oe  = 1'b1;
        end else if (series) begin
          next_drv.cable.hold_oe = 1'b1;
          next_drv.disp.hold_oe  = 1'b1;
        end
      end
      ST_LOW: begin
        // Weak clamp only on a released side: the wired-AND keeps it low
        if (series) begin
          next_drv.cable.hold_oe = lvl.cable.above_low_release;
          next_drv.disp.hold_oe  = lvl.disp.above_low_release;
        end
      end
      ST_HIGH_HOLD: begin
        // Display side is simply released to its own pull-up
        next_drv.cable.pull_high_oe = (next_cnt <= DRV_ON_LAST);
      end
      default: begin
        next_drv = DRV_OFF;
      end
    endcase
    if (!drv_en) begin
      next_drv = DRV_OFF;
    end
  end

  // State, counter and drive registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_HIGH;
      cnt   <= CNT_RESET;
      drv   <= DRV_OFF;
      armed <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      drv   <= next_drv;
      armed <= next_armed;
    end
  end

endmodule

module tbx_top
  import tbx_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          link_clk,
  input  wire logic          reset_n,
  input  wire logic          driver_enable_input,
  input  wire logic          mode,
  input  wire tbx_chan_lvl_t clk_lvl,
  input  wire tbx_chan_lvl_t dat_lvl,
  output tbx_chan_drv_t      clk_drv,
  output tbx_chan_drv_t      dat_drv
);

  tbx_chan_lvl_t  lk_lvl_meta [2];
  tbx_chan_lvl_t  lk_lvl      [2];
  tbx_chan_lvl_t  sy_lvl_meta [2];
  tbx_chan_lvl_t  sy_lvl      [2];
  tbx_chan_drv_t  sy_drv      [2];
  tbx_chan_drv_t  lk_drv_meta [2];
  logic [1:0]     ctl_meta;
  logic [1:0]     ctl;
  logic           series;

  // Pins are sampled by the link-side logic through two flip-flops
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_lvl_meta[0] <= LVL_RESET;
      lk_lvl_meta[1] <= LVL_RESET;
      lk_lvl[0]      <= LVL_RESET;
      lk_lvl[1]      <= LVL_RESET;
    end else begin
      lk_lvl_meta[0] <= clk_lvl;
      lk_lvl_meta[1] <= dat_lvl;
      lk_lvl[0]      <= lk_lvl_meta[0];
      lk_lvl[1]      <= lk_lvl_meta[1];
    end
  end

  // Levels cross into the core domain; each bit is an independent level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sy_lvl_meta[0] <= LVL_RESET;
      sy_lvl_meta[1] <= LVL_RESET;
      sy_lvl[0]      <= LVL_RESET;
      sy_lvl[1]      <= LVL_RESET;
      ctl_meta       <= 2'h0;
      ctl            <= 2'h0;
    end else begin
      sy_lvl_meta[0] <= lk_lvl[0];
      sy_lvl_meta[1] <= lk_lvl[1];
      sy_lvl[0]      <= sy_lvl_meta[0];
      sy_lvl[1]      <= sy_lvl_meta[1];
      ctl_meta       <= {mode, driver_enable_input};
      ctl            <= ctl_meta;
    end
  end

  assign series = ~ctl[1];

  // Two fully separate controllers share nothing but the control pins
  tbx_chan #(.IS_DATA(1'b0)) u_clk_chan (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .lvl     (sy_lvl[0]),
    .drv_en  (ctl[0]),
    .series  (series),
    .drv     (sy_drv[0])
  );

  tbx_chan #(.IS_DATA(1'b1)) u_dat_chan (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .lvl     (sy_lvl[1]),
    .drv_en  (ctl[0]),
    .series  (series),
    .drv     (sy_drv[1])
  );

  // Drive enables cross to the link side; the second stage feeds the pins
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_drv_meta[0] <= DRV_OFF;
      lk_drv_meta[1] <= DRV_OFF;
      clk_drv        <= DRV_OFF;
      dat_drv        <= DRV_OFF;
    end else begin
      lk_drv_meta[0] <= sy_drv[0];
      lk_drv_meta[1] <= sy_drv[1];
      clk_drv        <= lk_drv_meta[0];
      dat_drv        <= lk_drv_meta[1];
    end
  end

endmodule

/* verif/tbx_bus_model.sv */
// Far-side model: clients and pull-ups seen through the comparators
module tbx_bus_model
  import tbx_pkg::*;
(
  input  wire logic [1:0]    pull,
  input  wire tbx_chan_drv_t drv,
  output tbx_chan_lvl_t      lvl
);
  timeunit 1ns;
  timeprecision 100ps;
  // A pulldown wins; the weak clamp sits between the two thresholds
  function automatic tbx_side_lvl_t sense(logic low, logic hold);
    if (low)
      return 4'h9;
    if (hold)
      return 4'hd;
    return 4'h6;
  endfunction
  // Wired-AND of clients and the strong low driver on each side
  assign lvl = {sense(pull[1] | drv.cable.pull_low_oe, drv.cable.hold_oe),
                sense(pull[0] | drv.disp.pull_low_oe, drv.disp.hold_oe)};
endmodule

/* verif/tbx_monitor.sv */
// Concurrent checks on the extender drive outputs
module tbx_monitor
  import tbx_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          link_clk,
  input wire logic          reset_n,
  input wire logic          driver_enable_input,
  input wire logic          mode,
  input wire tbx_chan_lvl_t clk_lvl,
  input wire tbx_chan_lvl_t dat_lvl,
  input wire tbx_chan_drv_t clk_drv,
  input wire tbx_chan_drv_t dat_drv
);
  logic [5:0][7:0] r;
  // Saturating run counters, so long quiet spells never wrap round
  function automatic logic [7:0] run(logic [7:0] c, logic on);
    return on ? c + 8'(c != 8'hff) : 8'h00;
  endfunction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      r <= '0;
    else
      r <= {run(r[5], !clk_drv.cable.pull_high_oe),
            run(r[4], !clk_drv.cable.pull_low_oe),
            run(r[3], mode), run(r[2], !driver_enable_input),
            run(r[1], clk_drv.cable.pull_high_oe),
            run(r[0], clk_drv.cable.pull_low_oe)};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Widths allow one link period of quantisation either way
  sequence s_lo_end; $fell(clk_drv.cable.pull_low_oe); endsequence
  sequence s_hi_end; $fell(clk_drv.cable.pull_high_oe); endsequence
  a_low_width: assert property (
    s_lo_end |-> r[0] inside {[8'h54:8'h5c]})
    else $error("low drive width wrong");
  a_high_width: assert property (
    s_hi_end |-> r[1] inside {[8'h54:8'h5c]})
    else $error("pull-up width wrong");
  a_both_low: assert property (
    clk_drv.cable.pull_low_oe == clk_drv.disp.pull_low_oe &&
    dat_drv.cable.pull_low_oe == dat_drv.disp.pull_low_oe)
    else $error("sides not driven low together");
  a_disp_nopull: assert property (
    !clk_drv.disp.pull_high_oe && !dat_drv.disp.pull_high_oe)
    else $error("display side pulled up");
  a_off_quiet: assert property (
    r[2] >= 8'h18 |-> clk_drv == DRV_OFF && dat_drv == DRV_OFF)
    else $error("drive while disabled");
  a_par_nohold: assert property (r[3] >= 8'h18 |-> !(|{
    clk_drv.cable.hold_oe, clk_drv.disp.hold_oe,
    dat_drv.cable.hold_oe, dat_drv.disp.hold_oe}))
    else $error("clamp in parallel mode");
  a_holdoff_gap: assert property (
    $rose(clk_drv.cable.pull_high_oe) |-> r[4] >= 8'h20)
    else $error("release inside low holdoff");
  a_high_gap: assert property (
    $rose(clk_drv.cable.pull_low_oe) |-> r[5] >= 8'h20)
    else $error("fall inside high holdoff");
endmodule
bind tbx_top tbx_monitor mon_u (
  .sys_clk(sys_clk), .link_clk(link_clk), .reset_n(reset_n),
  .driver_enable_input(driver_enable_input), .mode(mode),
  .clk_lvl(clk_lvl), .dat_lvl(dat_lvl), .clk_drv(clk_drv), .dat_drv(dat_drv)
);

/* verif/tbx_top_tb.sv */
// Self-checking bench for the two-wire bus extender controllers
module tbx_top_tb
  import tbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic          sys_clk = 0;
  logic          link_clk = 0;
  logic          reset_n = 0;
  logic          driver_enable_input = 1;
  logic          mode = 1;
  logic [1:0]    pull [2] = '{2'h0, 2'h0};
  tbx_chan_lvl_t lvl [2];
  tbx_chan_drv_t drv [2];
  int            fails = 0;
  int            num_checks = 0;
  int            seed = 50455;
  int            ch, s, n;
  initial forever #10 sys_clk = ~sys_clk;
  // Link clock offset so its edges never line up with the core clock
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  tbx_top dut_u (.sys_clk(sys_clk), .link_clk(link_clk), .reset_n(reset_n),
    .driver_enable_input(driver_enable_input), .mode(mode),
    .clk_lvl(lvl[0]), .dat_lvl(lvl[1]), .clk_drv(drv[0]), .dat_drv(drv[1]));
  tbx_bus_model clk_m (.pull(pull[0]), .drv(drv[0]), .lvl(lvl[0]));
  tbx_bus_model dat_m (.pull(pull[1]), .drv(drv[1]), .lvl(lvl[1]));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (exp !== got) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Inputs change 2 ns after the core edge, outputs settled by then
  task automatic tick(int k);
    repeat (k) @(posedge sys_clk);
    #2;
  endtask
  // Bounded wait for a strong drive; hi picks the cable pull-up
  task automatic wait_drv(int c, logic hi, int lim);
    for (n = 0; n < lim; n++) begin
      if ((hi ? drv[c].cable.pull_high_oe : drv[c].cable.pull_low_oe) === 1)
        break;
      tick(1);
    end
    if (n == lim) begin
      check("wait", 16'h1, 16'h0);
      tally_and_finish();
    end
  endtask
  function automatic logic [4:0] lh(tbx_chan_drv_t d);
    return {d.cable.pull_high_oe, d.cable.pull_low_oe, d.cable.hold_oe,
            d.disp.pull_low_oe, d.disp.hold_oe};
  endfunction
  // Expected enables; the weak clamp only ever appears in series mode
  function automatic logic [4:0] want(logic hi, logic c, logic d);
    return {hi, 1'b0, !mode & c, 1'b0, !mode & d};
  endfunction
  // Each pass alternates channels so both holdoff exits are seen
  initial begin
    tick(20);
    reset_n = 1;
    tick(5);
    for (int i = 0; i < 8; i++) begin
      ch = i % 2;
      s = $random(seed) & 1;
      mode = 1'($random(seed));
      tick(40);
      check("idle", 16'({DRV_OFF, DRV_OFF}), 16'({drv[0], drv[1]}));
      pull[ch] = 2'h3; // Single edges with pauses, never a free clock
      wait_drv(ch, 0, 40);
      check("both low", 16'h1, 16'(drv[ch].disp.pull_low_oe));
      check("other quiet", 16'(DRV_OFF), 16'(drv[1-ch]));
      tick(30);
      pull[ch][s] = 1'b0;
      tick(70);
      check("holdoff", 16'(want(0, 1, 1)), 16'(lh(drv[ch])));
      tick(60);
      check("one free", 16'(want(0, s, !s)), 16'(lh(drv[ch])));
      pull[ch] = 2'h0;
      wait_drv(ch, 1, 40);
      check("pull up", 16'(want(1, 0, 0)), 16'(lh(drv[ch])));
      tick(20);
      pull[ch][s] = 1'b1;
      if (ch == 0) begin
        tick(300);
        check("high wait", 16'h0, 16'(drv[0].cable.pull_low_oe));
        pull[0] = 2'h0;
        tick(20);
        pull[0][s] = 1'b1;
      end
      wait_drv(ch, 0, 40);
      tick(200);
      driver_enable_input = 1'b0;
      tick(30);
      check("off", 16'h0, 16'({drv[0], drv[1]}));
      // Sensed levels lag the enable; let the release settle first
      pull[ch] = 2'h0;
      tick(20);
      driver_enable_input = 1'b1;
    end
    tally_and_finish();
  end
endmodule
